// File: core/crt_pkg.sv
// constants, field layouts and carrier types of the capture/reload timer
// assumes an 8051-style special-function-register port on the system clock
package crt_pkg;

  // ==========================================================
  // register addresses
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'hc8;
  localparam logic [7:0] ADDR_RELOAD_CAPTURE_LOW = 8'hca;
  localparam logic [7:0] ADDR_RELOAD_CAPTURE_HIGH = 8'hcb;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
  // shared registers holding one or two bits of this block
  localparam logic [7:0] ADDR_PIN_MODE = 8'ha6;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'ha8;
  localparam logic [7:0] ADDR_PRIORITY_LOW = 8'hb8;
  localparam logic [7:0] ADDR_PRIORITY_HIGH = 8'hb9;

  // ==========================================================
  // field positions in the shared registers
  localparam int BIT_OVERFLOW_OUTPUT_ENABLE = 1;
  localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
  localparam int BIT_TIMER_IRQ_ENABLE = 5;
  localparam int BIT_PRIORITY = 5;

  // ==========================================================
  // reset values and the count at which the counter wraps
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  // ==========================================================
  // timing: timer mode counts at half the system clock
  localparam int CLOCK_MHZ = 50;
  localparam int TIMER_DIVIDE = 2;

  // control register, bit 7 down to bit 0
  typedef struct packed {
    logic overflow_flag;
    logic external_edge_flag;
    logic receive_baud_select;
    logic transmit_baud_select;
    logic external_pin_enable;
    logic run_control;
    logic counter_select;
    logic capture_select;
  } crt_control_t;

  // one register access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } crt_sfr_req_t;

endpackage

// File: core/crt_timer.sv
// 16-bit capture/reload timer with baud clock supply and toggle output
// assumes a core that writes and reads registers with one-cycle strobes,
// and pins that arrive unsynchronised from outside the chip
`timescale 1ns/1ns
module crt_timer
  import crt_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // register port from the core
  input wire crt_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  // pins
  input wire logic count_input_pin,
  input wire logic external_trigger_pin,
  output logic overflow_toggle_output,
  output logic overflow_toggle_oe,
  // uart baud clocks
  input wire logic other_timer_overflow,
  output logic uart_rx_baud_tick,
  output logic uart_tx_baud_tick,
  // interrupt controller
  output logic irq_request,
  output logic [1:0] irq_priority
);

  // ==========================================================
  // declarations
  crt_control_t control; // control register
  logic [15:0] count; // counter value
  logic [15:0] reload_value; // reload/capture register
  logic overflow_output_enable;
  logic global_irq_enable;
  logic timer_irq_enable;
  logic priority_low_bit;
  logic priority_high_bit;
  logic toggle_state; // pin level
  logic half_tick; // timer-mode divider phase
  logic [1:0] count_pin_sync; // two-stage synchroniser
  logic [1:0] trigger_pin_sync;
  logic count_pin_last; // previous synchronised level
  logic trigger_pin_last;
  logic baud_mode; // either baud select set
  logic count_step; // one increment this cycle
  logic overflow; // counter wraps this cycle
  logic trigger_edge; // qualified falling edge
  logic do_reload;
  logic do_capture;
  logic wr_en;

  // falling edge between two sampled levels
  function automatic logic is_falling(input logic last, input logic now);
    return last & ~now;
  endfunction

  // write strobe of one address
  function automatic logic wr_at(input crt_sfr_req_t r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  assign wr_en = ce;

  // ==========================================================
  // pin synchronisers
  // the first stage is read only by the second one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_pin_sync <= 2'h3;
      trigger_pin_sync <= 2'h3;
      count_pin_last <= 1'b1;
      trigger_pin_last <= 1'b1;
    end else if (ce) begin
      count_pin_sync <= {count_pin_sync[0], count_input_pin};
      trigger_pin_sync <= {trigger_pin_sync[0], external_trigger_pin};
      count_pin_last <= count_pin_sync[1];
      trigger_pin_last <= trigger_pin_sync[1];
    end
  end

  // ==========================================================
  // event decode
  assign baud_mode = control.receive_baud_select | control.transmit_baud_select;

  // timer-mode divider; runs only while counting is allowed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      half_tick <= 1'b0;
    end else if (ce) begin
      if (control.run_control && !control.counter_select) begin
        half_tick <= ~half_tick;
      end else begin
        half_tick <= 1'b0;
      end
    end
  end

  always_comb begin
    if (!control.run_control) begin
      count_step = 1'b0;
    end else if (control.counter_select) begin
      count_step = is_falling(count_pin_last, count_pin_sync[1]);
    end else begin
      count_step = half_tick;
    end
  end

  assign overflow = count_step && (count == COUNT_MAX);

  assign trigger_edge = control.external_pin_enable && !baud_mode
    && is_falling(trigger_pin_last, trigger_pin_sync[1]);

  assign do_reload = (overflow && (baud_mode || !control.capture_select))
    || (trigger_edge && !control.capture_select);
  assign do_capture = trigger_edge && control.capture_select;

  // ==========================================================
  // counter; a core write wins over counting in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= RESET_WORD;
    end else if (wr_en) begin
      if (wr_at(sfr_req, ADDR_COUNT_LOW)) begin
        count[7:0] <= sfr_req.wdata;
      end else if (wr_at(sfr_req, ADDR_COUNT_HIGH)) begin
        count[15:8] <= sfr_req.wdata;
      end else if (do_reload) begin
        count <= reload_value;
      end else if (count_step) begin
        count <= count + 16'h0001;
      end
    end
  end

  // ==========================================================
  // reload/capture register; capture wins over a write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reload_value <= RESET_WORD;
    end else if (wr_en) begin
      if (do_capture) begin
        reload_value <= count;
      end else if (wr_at(sfr_req, ADDR_RELOAD_CAPTURE_LOW)) begin
        reload_value[7:0] <= sfr_req.wdata;
      end else if (wr_at(sfr_req, ADDR_RELOAD_CAPTURE_HIGH)) begin
        reload_value[15:8] <= sfr_req.wdata;
      end
    end
  end

  // ==========================================================
  // control register; hardware flag sets win over a clearing write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      control <= crt_control_t'(RESET_BYTE);
    end else if (wr_en) begin
      if (wr_at(sfr_req, ADDR_TIMER_CONTROL)) begin
        control <= crt_control_t'(sfr_req.wdata);
      end
      if (overflow && !baud_mode) begin
        control.overflow_flag <= 1'b1;
      end
      if (trigger_edge) begin
        control.external_edge_flag <= 1'b1;
      end
    end
  end

  // ==========================================================
  // bits held in shared registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overflow_output_enable <= 1'b0;
      global_irq_enable <= 1'b0;
      timer_irq_enable <= 1'b0;
      priority_low_bit <= 1'b0;
      priority_high_bit <= 1'b0;
    end else if (wr_en) begin
      if (wr_at(sfr_req, ADDR_PIN_MODE)) begin
        overflow_output_enable <= sfr_req.wdata[BIT_OVERFLOW_OUTPUT_ENABLE];
      end
      if (wr_at(sfr_req, ADDR_IRQ_ENABLE)) begin
        global_irq_enable <= sfr_req.wdata[BIT_GLOBAL_IRQ_ENABLE];
        timer_irq_enable <= sfr_req.wdata[BIT_TIMER_IRQ_ENABLE];
      end
      if (wr_at(sfr_req, ADDR_PRIORITY_LOW)) begin
        priority_low_bit <= sfr_req.wdata[BIT_PRIORITY];
      end
      if (wr_at(sfr_req, ADDR_PRIORITY_HIGH)) begin
        priority_high_bit <= sfr_req.wdata[BIT_PRIORITY];
      end
    end
  end

  // ==========================================================
  // overflow toggle pin; it toggles even when disabled so that
  // enabling it later does not glitch the phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      toggle_state <= 1'b0;
    end else if (ce) begin
      if (overflow) begin
        toggle_state <= ~toggle_state;
      end
    end
  end

  assign overflow_toggle_output = toggle_state;
  assign overflow_toggle_oe = overflow_output_enable;

  // ==========================================================
  // uart baud clocks; mode 1 and 3 gating is the uart's own job
  // receive clock source
  assign uart_rx_baud_tick = control.receive_baud_select ? overflow : other_timer_overflow;
  assign uart_tx_baud_tick = control.transmit_baud_select ? overflow : other_timer_overflow;

  // ==========================================================
  // interrupt request; flags stay until software clears them
  // enable gating
  assign irq_request = global_irq_enable && timer_irq_enable
    && (control.overflow_flag || control.external_edge_flag);
  assign irq_priority = {priority_high_bit, priority_low_bit};

  // ==========================================================
  // read port; data one cycle after the read strobe
  // shared registers return only this block's bits, the rest zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= RESET_BYTE;
      sfr_rvalid <= 1'b0;
    end else if (ce) begin
      sfr_rvalid <= sfr_req.rd;
      sfr_rdata <= RESET_BYTE;
      if (sfr_req.rd) begin
        unique case (sfr_req.addr)
          ADDR_TIMER_CONTROL: begin
            sfr_rdata <= control;
          end
          ADDR_RELOAD_CAPTURE_LOW: begin
            sfr_rdata <= reload_value[7:0];
          end
          ADDR_RELOAD_CAPTURE_HIGH: begin
            sfr_rdata <= reload_value[15:8];
          end
          ADDR_COUNT_LOW: begin
            sfr_rdata <= count[7:0];
          end
          ADDR_COUNT_HIGH: begin
            sfr_rdata <= count[15:8];
          end
          ADDR_PIN_MODE: begin
            sfr_rdata[BIT_OVERFLOW_OUTPUT_ENABLE] <= overflow_output_enable;
          end
          ADDR_IRQ_ENABLE: begin
            sfr_rdata[BIT_GLOBAL_IRQ_ENABLE] <= global_irq_enable;
            sfr_rdata[BIT_TIMER_IRQ_ENABLE] <= timer_irq_enable;
          end
          ADDR_PRIORITY_LOW: begin
            sfr_rdata[BIT_PRIORITY] <= priority_low_bit;
          end
          ADDR_PRIORITY_HIGH: begin
            sfr_rdata[BIT_PRIORITY] <= priority_high_bit;
          end
          // unmapped addresses read as zero
          default: begin
            sfr_rdata <= RESET_BYTE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_flag_on_overflow: assert property (
    ce && overflow && !baud_mode |=> control.overflow_flag)
    else $error("overflow flag not set after overflow");

  a_flag_baud_quiet: assert property (
    ce && baud_mode && !control.overflow_flag && !wr_at(sfr_req, ADDR_TIMER_CONTROL)
    |=> !control.overflow_flag)
    else $error("overflow flag set in baud mode");

  a_edge_flag_set: assert property (
    ce && trigger_edge |=> control.external_edge_flag)
    else $error("edge flag not set on trigger");

  a_rx_baud_source: assert property (
    uart_rx_baud_tick == (control.receive_baud_select ? overflow : other_timer_overflow))
    else $error("receive baud source wrong");

  a_tx_baud_source: assert property (
    control.transmit_baud_select && overflow |-> uart_tx_baud_tick)
    else $error("transmit baud tick missing");

  a_trigger_blocked: assert property (
    baud_mode || !control.external_pin_enable |-> !trigger_edge)
    else $error("trigger acted while disabled");

  a_count_hold: assert property (
    ce && !control.run_control && !sfr_req.wr && !do_reload |=> $stable(count))
    else $error("counter moved while stopped");

  a_timer_rate: assert property (
    ce && control.run_control && !control.counter_select && !half_tick
    |=> half_tick)
    else $error("timer divider stalled");

  a_reload_copy: assert property (
    ce && do_reload && !sfr_req.wr |=> count == $past(reload_value))
    else $error("reload did not copy value");

  a_capture_copy: assert property (
    ce && do_capture |=> reload_value == $past(count))
    else $error("capture did not copy count");

  a_toggle_pin: assert property (
    ce && overflow |=> overflow_toggle_output != $past(overflow_toggle_output))
    else $error("toggle pin missed overflow");

  a_irq_gate: assert property (
    irq_request |-> global_irq_enable && timer_irq_enable)
    else $error("request without enables");

  c_overflow_reload: cover property (ce && overflow && do_reload);
  c_trigger_capture: cover property (ce && do_capture);
  c_irq_raised: cover property (!irq_request ##1 irq_request);

endmodule

// File: tb/crt_core_model.sv
// core-side model of the register port: one-cycle strobes at the falling edge
// assumes the timer takes strobes at the rising edge and answers one edge later
`timescale 1ns/1ns
module crt_core_model
  import crt_pkg::*;
(
  // clock
  input wire logic clk,
  // register port
  output crt_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rvalid
);
  // idle bus from time zero, so no strobe reaches the timer during reset
  initial sfr_req = '0;

  // ==========================================================
  // write: strobe stands across exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clk);
    sfr_req <= '0;
  endtask

  // read: data stands only in the cycle after the taking edge,
  // so it is taken at the falling edge inside that cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk);
    sfr_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge clk);
    ok = sfr_rvalid;
    d = sfr_rdata;
    sfr_req <= '0;
  endtask

  task automatic clear_flags(input logic [7:0] keep);
    wr(8'hc8, keep & 8'h3f);
  endtask
endmodule

// File: tb/test_capture_reload_timer.sv
// self-checking bench of the capture/reload timer
// assumes the core model on the register port and pins driven at the falling edge
`timescale 1ns/1ns
module test_capture_reload_timer;
  import crt_pkg::*;
  logic clk, rst, ce, cnt_pin, trig_pin, oth_ovf;
  crt_sfr_req_t sfr_req;
  logic [7:0] sfr_rdata, rd_data;
  logic sfr_rvalid, ok, tog_out, tog_oe, rx_tick, tx_tick, irq;
  logic [1:0] prio;
  logic [15:0] c, r;
  int miscompares, n_compared, k, ticks;
  // addresses read back as zero after reset, last entry unmapped
  logic [7:0] regs [10] = '{8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'ha6, 8'ha8, 8'hb8,
                            8'hb9, 8'hc9};
  // modes in which a trigger edge must do nothing
  logic [7:0] ign [3] = '{8'h06, 8'h2e, 8'h1e};

  // ==========================================================
  // clock and instances
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  crt_timer u_crt_timer (.clk(clk), .rst(rst), .ce(ce), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .count_input_pin(cnt_pin),
    .external_trigger_pin(trig_pin), .overflow_toggle_output(tog_out),
    .overflow_toggle_oe(tog_oe), .other_timer_overflow(oth_ovf),
    .uart_rx_baud_tick(rx_tick), .uart_tx_baud_tick(tx_tick), .irq_request(irq),
    .irq_priority(prio));
  crt_core_model u_crt_core_model (.clk(clk), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid));

  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    u_crt_core_model.wr(a, d);
  endtask
  task automatic rdck(input logic [7:0] a, input logic [7:0] exp);
    u_crt_core_model.rd(a, rd_data, ok);
    check($sformatf("valid %h", a), {15'h0, ok}, 16'h0001);
    check($sformatf("reg %h", a), {8'h00, rd_data}, {8'h00, exp});
  endtask
  // 16-bit values go low byte first, high byte at the next address
  task automatic set16(input logic [7:0] a, input logic [15:0] v);
    w(a, v[7:0]);
    w(a + 8'h01, v[15:8]);
  endtask
  // falling edges held three cycles each, longer than the pin synchroniser
  task automatic pulse(input logic trig, input int n);
    repeat (n) begin
      if (trig) trig_pin = 1'b0;
      else cnt_pin = 1'b0;
      repeat (3) @(negedge clk);
      trig_pin = 1'b1;
      cnt_pin = 1'b1;
      repeat (3) @(negedge clk);
    end
    repeat (4) @(negedge clk);
  endtask
  // the toggle pin moves on every overflow, so it marks the overflow
  task automatic wait_tog();
    logic t0;
    t0 = tog_out;
    ticks = 0;
    for (int i = 0; i < 300 && tog_out === t0; i++) begin
      @(negedge clk);
      if (rx_tick === 1'b1) ticks++;
    end
    if (tog_out === t0) begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    cnt_pin = 1'b1;
    trig_pin = 1'b1;
    oth_ovf = 1'b0;
    void'($urandom(62));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    foreach (regs[i]) rdck(regs[i], 8'h00);
    for (int i = 0; i < 4; i++) begin
      r[7:0] = 8'($urandom);
      w(8'hca + 8'(i), r[7:0]);
      rdck(8'hca + 8'(i), r[7:0]);
    end
    repeat (10) @(negedge clk);
    rdck(8'hcd, r[7:0]);
    w(8'hb8, 8'h20);
    w(8'hb9, 8'hdf);
    @(negedge clk);
    check("priority", {14'h0, prio}, 16'h0001);
    rdck(8'hb9, 8'h00);
    w(8'hb9, 8'h20);
    @(negedge clk);
    check("priority", {14'h0, prio}, 16'h0003);
    $display("test registers ended");

    set16(8'hcc, 16'hfffe);
    r = {8'($urandom), 8'h00};
    set16(8'hca, r);
    w(8'ha6, 8'h02);
    w(8'ha8, 8'h20);
    w(8'hc8, 8'h04);
    wait_tog();
    check("irq masked", irq, 16'h0000);
    rdck(8'hc8, 8'h84);
    rdck(8'hcd, r[15:8]);
    check("toggle", {tog_oe, tog_out}, 16'h0003);
    w(8'ha8, 8'ha0);
    check("irq", irq, 16'h0001);
    u_crt_core_model.clear_flags(8'h00);
    check("irq cleared", irq, 16'h0000);
    $display("test overflow ended");

    // timer rate is half the clock
    set16(8'hcc, 16'h0000);
    w(8'hc8, 8'h04);
    // clock enable low freezes the count, so the rate window is unchanged
    repeat (10) @(negedge clk);
    ce = 1'b0;
    repeat (20) @(negedge clk);
    ce = 1'b1;
    repeat (10) @(negedge clk);
    w(8'hc8, 8'h00);
    u_crt_core_model.rd(8'hcc, rd_data, ok);
    check("timer rate", {15'h0, rd_data >= 8'd9 && rd_data <= 8'd12}, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      k = 1 + $urandom % 8;
      c = 16'($urandom) & 16'hfff0;
      set16(8'hcc, c);
      w(8'hc8, 8'h06);
      pulse(1'b0, k);
      w(8'hc8, 8'h00);
      rdck(8'hcc, c[7:0] + 8'(k));
    end
    $display("test counting ended");

    c = 16'($urandom);
    set16(8'hcc, c);
    w(8'hc8, 8'h0f);
    pulse(1'b1, 1);
    rdck(8'hca, c[7:0]);
    rdck(8'hcb, c[15:8]);
    rdck(8'hc8, 8'h4f);
    w(8'hc8, 8'h0e);
    r = ~c;
    set16(8'hca, r);
    pulse(1'b1, 1);
    rdck(8'hcc, r[7:0]);
    rdck(8'hc8, 8'h4e);
    foreach (ign[i]) begin
      w(8'hc8, ign[i]);
      set16(8'hcc, c);
      pulse(1'b1, 1);
      rdck(8'hcc, c[7:0]);
      rdck(8'hc8, ign[i]);
    end
    $display("test trigger ended");

    for (int i = 0; i < 4; i++) begin
      w(8'hc8, {2'b00, 2'(i), 4'h0});
      @(negedge clk);
      oth_ovf = 1'b1;
      #1;
      check("rx tick", rx_tick, {15'h0, !i[1]});
      check("tx tick", tx_tick, {15'h0, !i[0]});
      @(negedge clk);
      oth_ovf = 1'b0;
    end
    r = {8'($urandom), 8'h00};
    set16(8'hca, r);
    set16(8'hcc, 16'hfffe);
    w(8'hc8, 8'h25);
    wait_tog();
    check("rx ticks", 16'(ticks), 16'h0001);
    rdck(8'hc8, 8'h25);
    rdck(8'hcd, r[15:8]);
    w(8'hc8, 8'h00);
    $display("test baud ended");

    // capture mode wraps on overflow instead of reloading
    set16(8'hca, 16'hff00);
    set16(8'hcc, 16'hfffe);
    w(8'hc8, 8'h05);
    wait_tog();
    rdck(8'hcd, 8'h00);
    rdck(8'hc8, 8'h85);
    w(8'hc8, 8'h00);
    $display("test wrap ended");
    test_done();
  end
endmodule
